// file: src/vcu_lane_cmp.sv
// vcu_lane_cmp: one lane of equality / less-or-equal compare
// assumes operands are already sliced to the lane width
`timescale 1ns/1ps
`default_nettype none
module vcu_lane_cmp #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] a,        // first source element
  input  wire logic [W-1:0] b,        // second source or immediate
  input  wire logic         eq_mode,  // equality instead of less-or-equal
  input  wire logic         sgn,      // signed less-or-equal
  output logic      [W-1:0] res       // all ones when true
);
  logic hit;
  always_comb begin
    if (eq_mode) begin
      hit = (a == b);
    end else if (sgn) begin
      hit = ($signed(a) <= $signed(b));
    end else begin
      hit = ({1'b0, a} <= {1'b0, b});
    end
    res = {W{hit}};
  end
endmodule : vcu_lane_cmp
`default_nettype wire

// file: src/vcu_pkg.sv
// vcu_pkg: shared constants and types of the vector compare unit
// assumes the pipeline decodes instructions into the op codes below
package vcu_pkg;

  localparam int VREG_BITS = 128;
  localparam int GPR_BITS  = 32;

  // element format encodings
  localparam logic [1:0] FMT_BYTE = 2'h0;
  localparam logic [1:0] FMT_HALF = 2'h1;
  localparam logic [1:0] FMT_WORD = 2'h2;
  localparam logic [1:0] FMT_DBL  = 2'h3;

  // control register selectors
  localparam logic [4:0] SEL_IMPL   = 5'h00;
  localparam logic [4:0] SEL_CSR    = 5'h01;
  localparam logic [4:0] SEL_PRIV_LO = 5'h02;
  localparam logic [4:0] SEL_PRIV_HI = 5'h07;

  // privileged-regs-present flag position in the implementation register
  localparam int PRIV_PRESENT_BIT = 17;

  typedef enum logic [2:0] {
    VCU_OP_VEQ,
    VCU_OP_IEQ,
    VCU_OP_VLES,
    VCU_OP_VLEU,
    VCU_OP_ILES,
    VCU_OP_ILEU,
    VCU_OP_CFRD
  } vcu_op_t;

  typedef enum logic [1:0] {
    VCU_EXC_NONE,
    VCU_EXC_RESERVED,
    VCU_EXC_DISABLED,
    VCU_EXC_COP0
  } vcu_exc_t;

endpackage : vcu_pkg

// file: src/vcu_top.sv
// vcu_top: element-wise integer compare and control-register read
// assumes one decoded operation per issue pulse on the core clock
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - immediate equal: lane equals sign-extended immediate
// - vector equal: lanes of both sources equal
// - true compare sets every element bit
// - format selects byte/half/word/double lanes
// - signed vector less-or-equal compare
// - unsigned vector compare via zero prefix
// - signed immediate less-or-equal compare
// - immediate sign-extended from its bit four
// - unsigned immediate zero-extended, less-or-equal
// - no operand-value dependent exceptions
// - reserved or disabled raises exception
// - control read copies selected register
// - selectors 0 and 1 always readable
// - selectors 2..7 need privileged regs present
// - selectors 2..7 need coprocessor 0 usable
// - absent or reserved register reads zero
// - operands are integers in element format
module vcu_top
  import vcu_pkg::*;
#(
  parameter int VB = VREG_BITS
) (
  input  wire logic              clock,       // core clock, 40 MHz
  input  wire logic              rstn,        // async reset, active low
  input  wire logic              issue,       // operation valid pulse
  input  wire vcu_op_t           op,          // decoded operation
  input  wire logic              supported,   // op is implemented
  input  wire logic              ext_enabled, // vector extension enabled
  input  wire logic              cop0_usable, // coprocessor 0 usable
  input  wire logic [1:0]        element_format, // lane size
  input  wire logic [VB-1:0]     vector_source_first,  // first source
  input  wire logic [VB-1:0]     vector_source_second, // second source
  input  wire logic [4:0]        imm5,        // signed or unsigned imm
  input  wire logic [4:0]        vector_dest_idx, // destination index
  input  wire logic [4:0]        control_reg_selector, // cs field
  input  wire logic [4:0]        dest_general_register, // rd field
  input  wire logic [GPR_BITS-1:0] implementation_register, // sel 0
  input  wire logic [GPR_BITS-1:0] control_status_register, // sel 1
  input  wire logic [GPR_BITS-1:0] access_register,  // sel 2
  input  wire logic [GPR_BITS-1:0] save_register,    // sel 3
  input  wire logic [GPR_BITS-1:0] modify_register,  // sel 4
  input  wire logic [GPR_BITS-1:0] request_register, // sel 5
  input  wire logic [GPR_BITS-1:0] map_register,     // sel 6
  input  wire logic [GPR_BITS-1:0] unmap_register,   // sel 7
  output logic                   vec_we,      // write vector destination
  output logic      [4:0]        vec_waddr,   // vector destination index
  output logic      [VB-1:0]     vector_destination, // compare result
  output logic                   gpr_we,      // write general register
  output logic      [4:0]        gpr_waddr,   // general register index
  output logic      [GPR_BITS-1:0] gpr_wdata, // control register value
  output logic                   exc_valid,   // exception pulse
  output var vcu_exc_t           exc_code     // exception cause
);

  // the doubleword lane array needs whole 64-bit lanes
  if (VB % 64 != 0 || VB < 64) begin : g_bad_width
    $error("vcu_top: VB must be a positive multiple of 64");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic                vec_we;
    logic [4:0]          vec_waddr;
    logic [VB-1:0]       vdest;
    logic                gpr_we;
    logic [4:0]          gpr_waddr;
    logic [GPR_BITS-1:0] gpr_wdata;
    logic                exc_valid;
    vcu_exc_t            exc_code;
  } vcu_state_t;

  vcu_state_t st;
  vcu_state_t next_st;

  // ------------------------------------------------------------------
  // lane compare arrays
  // ------------------------------------------------------------------
  logic is_imm;
  logic is_eq;
  logic is_sgn;
  always_comb begin
    is_imm = (op == VCU_OP_IEQ) || (op == VCU_OP_ILES) ||
             (op == VCU_OP_ILEU);
    is_eq  = (op == VCU_OP_VEQ) || (op == VCU_OP_IEQ);
    is_sgn = (op == VCU_OP_VLES) || (op == VCU_OP_ILES);
  end

  // unsigned immediate form zero-extends, the others sign-extend
  logic ext_bit;
  assign ext_bit = (op == VCU_OP_ILEU) ? 1'b0 : imm5[4];

  logic [VB-1:0] res_b;
  logic [VB-1:0] res_h;
  logic [VB-1:0] res_w;
  logic [VB-1:0] res_d;

  // all four widths evaluate in parallel; format only picks the result
  genvar g;
  generate
    for (g = 0; g < VB/8; g++) begin : g_b
      vcu_lane_cmp #(.W(8)) u_cmp (
        .a       (vector_source_first[8*g +: 8]),
        .b       (is_imm ? {{3{ext_bit}}, imm5}
                         : vector_source_second[8*g +: 8]),
        .eq_mode (is_eq),
        .sgn     (is_sgn),
        .res     (res_b[8*g +: 8])
      );
    end
    for (g = 0; g < VB/16; g++) begin : g_h
      vcu_lane_cmp #(.W(16)) u_cmp (
        .a       (vector_source_first[16*g +: 16]),
        .b       (is_imm ? {{11{ext_bit}}, imm5}
                         : vector_source_second[16*g +: 16]),
        .eq_mode (is_eq),
        .sgn     (is_sgn),
        .res     (res_h[16*g +: 16])
      );
    end
    for (g = 0; g < VB/32; g++) begin : g_w
      vcu_lane_cmp #(.W(32)) u_cmp (
        .a       (vector_source_first[32*g +: 32]),
        .b       (is_imm ? {{27{ext_bit}}, imm5}
                         : vector_source_second[32*g +: 32]),
        .eq_mode (is_eq),
        .sgn     (is_sgn),
        .res     (res_w[32*g +: 32])
      );
    end
    for (g = 0; g < VB/64; g++) begin : g_d
      vcu_lane_cmp #(.W(64)) u_cmp (
        .a       (vector_source_first[64*g +: 64]),
        .b       (is_imm ? {{59{ext_bit}}, imm5}
                         : vector_source_second[64*g +: 64]),
        .eq_mode (is_eq),
        .sgn     (is_sgn),
        .res     (res_d[64*g +: 64])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  logic priv_sel;
  logic priv_present;
  always_comb begin
    priv_sel     = (control_reg_selector >= SEL_PRIV_LO) &&
                   (control_reg_selector <= SEL_PRIV_HI);
    priv_present = implementation_register[PRIV_PRESENT_BIT];
    next_st           = st;
    next_st.vec_we    = 1'b0;
    next_st.gpr_we    = 1'b0;
    next_st.exc_valid = 1'b0;
    next_st.exc_code  = VCU_EXC_NONE;
    if (issue) begin
      // only decode and enable checks raise; data never does
      if (!supported) begin
        next_st.exc_valid = 1'b1;
        next_st.exc_code  = VCU_EXC_RESERVED;
      end else if (!ext_enabled) begin
        next_st.exc_valid = 1'b1;
        next_st.exc_code  = VCU_EXC_DISABLED;
      end else if (op == VCU_OP_CFRD) begin
        next_st.gpr_waddr = dest_general_register;
        next_st.gpr_wdata = '0;
        next_st.gpr_we    = 1'b1;
        if (control_reg_selector == SEL_IMPL) begin
          next_st.gpr_wdata = implementation_register;
        end else if (control_reg_selector == SEL_CSR) begin
          next_st.gpr_wdata = control_status_register;
        end else if (priv_sel && priv_present) begin
          if (!cop0_usable) begin
            next_st.gpr_we    = 1'b0;
            next_st.exc_valid = 1'b1;
            next_st.exc_code  = VCU_EXC_COP0;
            // a refused read leaves the last written value standing
            next_st.gpr_waddr = st.gpr_waddr;
            next_st.gpr_wdata = st.gpr_wdata;
          end else begin
            case (control_reg_selector[2:0])
              3'h2:    next_st.gpr_wdata = access_register;
              3'h3:    next_st.gpr_wdata = save_register;
              3'h4:    next_st.gpr_wdata = modify_register;
              3'h5:    next_st.gpr_wdata = request_register;
              3'h6:    next_st.gpr_wdata = map_register;
              3'h7:    next_st.gpr_wdata = unmap_register;
              default: next_st.gpr_wdata = '0;
            endcase
          end
        end
      end else begin
        next_st.vec_we    = 1'b1;
        next_st.vec_waddr = vector_dest_idx;
        case (element_format)
          FMT_BYTE: next_st.vdest = res_b;
          FMT_HALF: next_st.vdest = res_h;
          FMT_WORD: next_st.vdest = res_w;
          FMT_DBL:  next_st.vdest = res_d;
          default:  next_st.vdest = res_b;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign vec_we             = st.vec_we;
  assign vec_waddr          = st.vec_waddr;
  assign vector_destination = st.vdest;
  assign gpr_we             = st.gpr_we;
  assign gpr_waddr          = st.gpr_waddr;
  assign gpr_wdata          = st.gpr_wdata;
  assign exc_valid          = st.exc_valid;
  assign exc_code           = st.exc_code;

endmodule : vcu_top
`default_nettype wire

// file: verif/vcu_asserts.sv
// vcu_asserts: port-level timing checks of the compare unit
// assumes it is bound onto vcu_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module vcu_asserts
  import vcu_pkg::*;
(
  input wire logic                clock,                   // core clock
  input wire logic                rstn,                    // async reset
  input wire logic                issue,                   // op valid
  input wire vcu_op_t             op,                      // decoded op
  input wire logic                supported,               // op known
  input wire logic                ext_enabled,             // extension on
  input wire logic                cop0_usable,             // cop0 usable
  input wire logic [4:0]          vector_dest_idx,         // dest index
  input wire logic [4:0]          control_reg_selector,    // selector
  input wire logic [GPR_BITS-1:0] implementation_register, // sel 0
  input wire logic [GPR_BITS-1:0] control_status_register, // sel 1
  input wire logic                vec_we,                  // vector write
  input wire logic [4:0]          vec_waddr,               // vector index
  input wire logic                gpr_we,                  // gpr write
  input wire logic [GPR_BITS-1:0] gpr_wdata,               // gpr data
  input wire logic                exc_valid,               // exception
  input wire vcu_exc_t            exc_code                 // cause
);
  // ----------------------------------------
  // answers one cycle after the issue edge
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic priv;
  assign priv = control_reg_selector inside {[SEL_PRIV_LO:SEL_PRIV_HI]}
    && implementation_register[PRIV_PRESENT_BIT];
  sequence s_take;
    issue && supported && ext_enabled;
  endsequence
  sequence s_read;
    s_take ##0 op == VCU_OP_CFRD;
  endsequence
  a_one_answer: assert property (
    issue |=> $onehot({vec_we, gpr_we, exc_valid}))
    else $error("not exactly one answer");
  a_reserved_exc: assert property (
    issue && !supported |=> exc_valid && exc_code == VCU_EXC_RESERVED)
    else $error("reserved cause missing");
  a_disabled_exc: assert property (
    issue && supported && !ext_enabled
    |=> exc_valid && exc_code == VCU_EXC_DISABLED)
    else $error("disabled cause missing");
  a_cop0_exc: assert property (
    s_read ##0 priv && !cop0_usable
    |=> exc_valid && exc_code == VCU_EXC_COP0)
    else $error("cop0 cause missing");
  a_cmp_write: assert property (
    s_take ##0 op != VCU_OP_CFRD
    |=> vec_we && vec_waddr == $past(vector_dest_idx))
    else $error("vector write missing");
  a_read_write: assert property (
    s_read ##0 !(priv && !cop0_usable) |=> gpr_we)
    else $error("gpr write missing");
  a_csr_copy: assert property (
    s_read ##0 control_reg_selector == SEL_CSR
    |=> gpr_wdata == $past(control_status_register))
    else $error("status copy wrong");
  a_absent_zero: assert property (
    s_read ##0 (control_reg_selector > SEL_PRIV_HI
    || (control_reg_selector >= SEL_PRIV_LO
    && !implementation_register[PRIV_PRESENT_BIT])) |=> gpr_wdata == '0)
    else $error("absent register not zero");
endmodule : vcu_asserts
bind vcu_top vcu_asserts u_chk (.clock, .rstn, .issue, .op, .supported,
  .ext_enabled, .cop0_usable, .vector_dest_idx, .control_reg_selector,
  .implementation_register, .control_status_register, .vec_we, .vec_waddr,
  .gpr_we, .gpr_wdata, .exc_valid, .exc_code);
`default_nettype wire

// file: verif/vcu_ctl_model.sv
// vcu_ctl_model: extension control registers as the core presents them
// assumes the bench sets the privileged-registers flag
`timescale 1ns/1ps
`default_nettype none
module vcu_ctl_model
  import vcu_pkg::*;
(
  input  wire logic           clock,   // core clock
  input  wire logic           rstn,    // async reset
  input  wire logic           priv,    // privileged regs present
  output logic [GPR_BITS-1:0] regs [8] // selectors 0..7
);
  // ----------------------------------------
  // register values
  // ----------------------------------------
  logic [GPR_BITS-1:0] tick;
  // status word moves every cycle so a stale sample shows up
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) tick <= '0;
    else tick <= tick + 32'h1;
  end
  always_comb begin
    for (int k = 0; k < 8; k++) regs[k] = 32'hA5C0_0000 | 32'(k * 273);
    regs[0][PRIV_PRESENT_BIT] = priv;
    regs[1] = tick;
  end
endmodule : vcu_ctl_model
`default_nettype wire

// file: verif/vector_integer_compare_unit_test.sv
// vector_integer_compare_unit_test: random self-checking bench
// assumes vcu_top at default width, vcu_ctl_model as register source
`timescale 1ns/1ps
`default_nettype none
module vector_integer_compare_unit_test;
  import vcu_pkg::*;
  logic clock, rstn, issue, supported, ext_enabled, cop0_usable, priv;
  logic vec_we, gpr_we, exc_valid;
  vcu_op_t op;
  vcu_exc_t exc_code, ec;
  logic [1:0] element_format, ek;
  logic [4:0] imm5, vector_dest_idx, control_reg_selector, ea;
  logic [4:0] dest_general_register, vec_waddr, gpr_waddr;
  logic [127:0] vector_source_first, vector_source_second;
  logic [127:0] vector_destination, ed;
  logic [GPR_BITS-1:0] gpr_wdata, regs [8];
  logic [63:0] seed;
  int mismatches = 0;
  int checks = 0;
  vcu_ctl_model u_ctl (.clock, .rstn, .priv, .regs);
  vcu_top dut (.clock, .rstn, .issue, .op, .supported, .ext_enabled,
    .cop0_usable, .element_format, .vector_source_first,
    .vector_source_second, .imm5, .vector_dest_idx, .control_reg_selector,
    .dest_general_register, .implementation_register(regs[0]),
    .control_status_register(regs[1]), .access_register(regs[2]),
    .save_register(regs[3]), .modify_register(regs[4]),
    .request_register(regs[5]), .map_register(regs[6]),
    .unmap_register(regs[7]), .vec_we, .vec_waddr, .vector_destination,
    .gpr_we, .gpr_waddr, .gpr_wdata, .exc_valid, .exc_code);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [63:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 7;
    seed ^= seed << 17;
    return seed;
  endfunction : rnd
  function automatic logic [127:0] rep(logic [1:0] f, logic [63:0] v);
    for (int i = 0; i < 128; i++) rep[i] = v[i % (8 << f)];
  endfunction : rep
  function automatic logic [127:0] exp_vec(vcu_op_t o, logic [1:0] f,
      logic [127:0] a, logic [127:0] b, logic [4:0] im);
    int w;
    logic sg, c;
    logic [63:0] x, y;
    w = 8 << f;
    sg = !(o inside {VCU_OP_VLEU, VCU_OP_ILEU});
    for (int i = 0; i < 128 / w; i++) begin
      for (int k = 0; k < 64; k++) begin
        x[k] = (k < w) ? a[i*w+k] : sg & a[i*w+w-1];
        y[k] = (k < w) ? b[i*w+k] : sg & b[i*w+w-1];
      end
      if (o inside {VCU_OP_IEQ, VCU_OP_ILES, VCU_OP_ILEU})
        y = {{59{sg & im[4]}}, im};
      if (o inside {VCU_OP_VEQ, VCU_OP_IEQ}) c = x == y;
      else if (sg) c = $signed(x) <= $signed(y);
      else c = x <= y;
      for (int k = 0; k < w; k++) exp_vec[i*w+k] = c;
    end
  endfunction : exp_vec
  task automatic cmp(input logic [135:0] g, input logic [135:0] w);
    checks++;
    if (g !== w) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, w);
    end
  endtask : cmp
  task automatic check();
    cmp(136'({vec_we, gpr_we, exc_valid}),
        136'({ek == 1, ek == 2, ek == 3}));
    cmp(136'(exc_code), 136'(ek == 2'h3 ? ec : VCU_EXC_NONE));
    if (ek == 2'h1) cmp(136'({vec_waddr, vector_destination}),
                        136'({ea, ed}));
    if (ek == 2'h2) cmp(136'({gpr_waddr, gpr_wdata}),
                        136'({ea, ed[31:0]}));
  endtask : check
  // drive one op (or idle) at an edge, check the previous one
  task automatic step(input logic quiet);
    logic [63:0] r;
    logic [127:0] a;
    vcu_op_t o;
    logic [4:0] im, s;
    r = rnd();
    o = vcu_op_t'((r[2:0] == 3'h7) ? 3'h6 : r[2:0]);
    im = r[12:8];
    s = {1'b0, r[16:13]};
    // lanes sit near the immediate so equal and boundary cases are common
    a = rep(r[4:3], {{59{im[4] & (o != VCU_OP_ILEU)}}, im});
    a ^= {rnd(), rnd()} & {rnd(), rnd()} & (r[5] ? {rnd(), rnd()} : '1);
    @(posedge clock);
    issue <= !quiet && r[29:27] != 3'h0;
    op <= o;
    element_format <= r[4:3];
    imm5 <= im;
    control_reg_selector <= s;
    supported <= |r[20:17];
    ext_enabled <= |r[24:21];
    cop0_usable <= r[25];
    priv <= r[26];
    dest_general_register <= r[34:30];
    vector_dest_idx <= r[39:35];
    vector_source_first <= a;
    vector_source_second <= a ^ ({rnd(), rnd()} & {rnd(), rnd()}
                                 & {rnd(), rnd()});
    #1;
    check();
    ek = !issue ? 2'h0 : (!supported || !ext_enabled) ? 2'h3
      : o != VCU_OP_CFRD ? 2'h1
      : (s inside {[2:7]} && priv && !cop0_usable) ? 2'h3 : 2'h2;
    ec = !supported ? VCU_EXC_RESERVED
      : !ext_enabled ? VCU_EXC_DISABLED : VCU_EXC_COP0;
    ea = (ek == 2'h2) ? dest_general_register : vector_dest_idx;
    ed = exp_vec(o, r[4:3], a, vector_source_second, im);
    if (ek == 2'h2)
      ed = (s < 2 || (s < 8 && priv))
        ? 128'(regs[s[2:0]]) : '0;
  endtask : step
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    repeat (3000) @(posedge clock);
    mismatches++;
    results();
  end
  initial begin
    seed = 64'hF595;
    {rstn, issue, supported, ext_enabled, cop0_usable, priv} = '0;
    op = VCU_OP_VEQ;
    {element_format, imm5, vector_dest_idx, control_reg_selector} = '0;
    dest_general_register = '0;
    {vector_source_first, vector_source_second} = '0;
    ek = 2'h0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    step(1'b1);
    $display("test reset done");
    repeat (900) step(1'b0);
    $display("test random done");
    @(posedge clock);
    rstn <= 1'b0;
    issue <= 1'b0;
    ek = 2'h0;
    #1;
    check();
    @(posedge clock);
    rstn <= 1'b1;
    repeat (100) step(1'b0);
    @(posedge clock);
    issue <= 1'b0;
    #1;
    check();
    $display("test mid reset done");
    results();
  end
endmodule : vector_integer_compare_unit_test
`default_nettype wire
